// ==== src/swt_watchdog.sv ====
// Function
// RULE1: Open pin 1600 ms, pulled high 200 ms.
// RULE2: Enable pin low disables watchdog, ignores kicks.
// RULE3: Capacitor timeout from constant-current charge time.
// RULE4: Standard variant: 3.23 ms/nF plus 0.381 ms.
// RULE5: Extended variant: 77.4 ms/nF plus 55 ms.
// RULE6: Capacitor timeout within 0.905 to 1.095 typical.
// RULE7: Host kicks before minimum timeout elapses.
// RULE8: Fault released when disabled, asserts on expiry.
// RULE9: Board uses capacitor from 100 pF to 1 uF.
// RULE10: Undervoltage must persist 6 us before reset.
// RULE11: Reset asserted disables watchdog, ignores kicks.
// RULE12: Only falling kick edges retrigger the timer.
// RULE13: Fault held for reset delay, then released.
// RULE14: Kicks ignored 150 us after enabling.
// RULE15: Counter on timebase, reloaded, latched terminal count.
`timescale 1ns/1ps

module swt_watchdog
    import swt_pkg::*;
#(
    parameter bit                    EXTENDED = 1'b0,
    parameter logic [`SWT_CNT_W-1:0] LONG_US  =
        `SWT_CNT_W'(`SWT_LONG_MS * `SWT_US_PER_MS),
    parameter logic [`SWT_CNT_W-1:0] SHORT_US =
        `SWT_CNT_W'(`SWT_SHORT_MS * `SWT_US_PER_MS),
    parameter logic [`SWT_CNT_W-1:0] RST_US   =
        `SWT_CNT_W'(`SWT_RST_DELAY_MS * `SWT_US_PER_MS)
) (
    input  wire logic                  clk,                 // 25 MHz clock
    input  wire logic                  nrst,                // Async reset
    input  wire logic                  watchdog_enable_pin, // High enables
    input  wire logic                  watchdog_kick_input, // Falling kicks
    input  wire logic [1:0]            timeout_select_pin,  // Strap kind
    input  wire logic [`SWT_CAP_W-1:0] timing_capacitor,    // Cap in pF
    input  wire logic                  undervoltage_detect, // Below thresh
    output logic                       watchdog_fault_out,  // Pin level
    output logic                       watchdog_fault_oe,   // Pulls low
    output logic                       reset_out,           // Pin level
    output logic                       reset_oe             // Pulls low
);

    localparam logic [`SWT_TICK_W-1:0] TICK_LAST =
        `SWT_TICK_W'(`SWT_CLK_MHZ - 1);
    localparam logic [`SWT_GL_W-1:0]   GL_CYC    =
        `SWT_GL_W'(`SWT_GLITCH_US * `SWT_CLK_MHZ);
    localparam logic [`SWT_SU_W-1:0]   SETUP_CYC =
        `SWT_SU_W'(`SWT_SETUP_US * `SWT_CLK_MHZ);

    swt_state_t s;
    swt_state_t next_s;

    logic                   tick;
    logic                   en;
    logic                   kick_fall;
    logic                   wd_run;
    logic                   kick_ok;
    logic [`SWT_CNT_W-1:0]  timeout;

    function automatic logic [`SWT_CNT_W-1:0] calc_timeout(
        input swt_sel_t              sel,
        input logic [`SWT_CAP_W-1:0] cap
    );
        logic [`SWT_PROD_W-1:0] prod;
        prod = '0;
        unique case (sel)
            SWT_SEL_PULLUP: calc_timeout = SHORT_US;              // [RULE1]
            SWT_SEL_CAP: begin
                // Typical charge time; digital timebase is exact [RULE6]
                if (EXTENDED) begin
                    prod = `SWT_PROD_W'(cap) * `SWT_EXT_MUL_X10;
                    calc_timeout = `SWT_CNT_W'(prod / `SWT_EXT_DIV
                        + `SWT_EXT_OFS_MS * `SWT_US_PER_MS);      // [RULE5]
                end else begin
                    prod = `SWT_PROD_W'(cap) * `SWT_STD_MUL_X100;
                    calc_timeout = `SWT_CNT_W'(prod / `SWT_STD_DIV
                        + `SWT_STD_OFS_US);                       // [RULE4]
                end
            end
            default: calc_timeout = LONG_US;                      // [RULE1]
        endcase
    endfunction : calc_timeout

    always_comb begin
        tick      = (s.tick_cnt == TICK_LAST);
        en        = s.en_s[1];
        kick_fall = s.kick_s[2] & ~s.kick_s[1];                   // [RULE12]
        wd_run    = en & ~s.rst_active;                   // [RULE2] [RULE11]
        kick_ok   = kick_fall & (s.setup_cnt == '0);              // [RULE14]
        timeout   = calc_timeout(s.sel, s.cap);           // [RULE3] [RULE15]
    end

    always_comb begin
        next_s        = s;
        next_s.en_s   = {s.en_s[1:0], watchdog_enable_pin};
        next_s.kick_s = {s.kick_s[1:0], watchdog_kick_input};
        next_s.uv_s   = {s.uv_s[0], undervoltage_detect};
        next_s.sel_s0 = timeout_select_pin;
        next_s.sel_s1 = s.sel_s0;
        next_s.cap_s0 = timing_capacitor;
        next_s.cap_s1 = s.cap_s0;
        next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;

        // Undervoltage must persist before reset trips
        if (!s.uv_s[1]) begin
            next_s.uv_cnt = '0;                                   // [RULE10]
        end else if (s.uv_cnt != GL_CYC) begin
            next_s.uv_cnt = s.uv_cnt + 1'b1;
        end

        if (s.uv_s[1] && s.uv_cnt == GL_CYC) begin
            next_s.rst_active = 1'b1;                             // [RULE10]
            next_s.rst_cnt    = RST_US;
        end else if (s.rst_active && tick) begin
            if (s.rst_cnt == '0) begin
                // Strap evaluated each time the supply becomes valid
                next_s.rst_active = 1'b0;
                next_s.sel = (s.sel_s1 == 2'h1) ? SWT_SEL_PULLUP :
                             (s.sel_s1 == 2'h2) ? SWT_SEL_CAP :
                             SWT_SEL_OPEN;                        // [RULE15]
                next_s.cap = s.cap_s1;
            end else begin
                next_s.rst_cnt = s.rst_cnt - 1'b1;
            end
        end

        if (en && !s.en_s[2]) begin
            next_s.setup_cnt = SETUP_CYC;                         // [RULE14]
        end else if (s.setup_cnt != '0) begin
            next_s.setup_cnt = s.setup_cnt - 1'b1;
        end

        if (!wd_run) begin
            next_s.wd_cnt    = timeout;                   // [RULE2] [RULE11]
            next_s.fault     = 1'b0;                              // [RULE8]
            next_s.fault_cnt = '0;
        end else if (s.fault) begin
            if (tick) begin
                if (s.fault_cnt == '0) begin
                    next_s.fault  = 1'b0;                         // [RULE13]
                    next_s.wd_cnt = timeout;
                end else begin
                    next_s.fault_cnt = s.fault_cnt - 1'b1;
                end
            end
        end else if (kick_ok) begin
            next_s.wd_cnt = timeout;                              // [RULE15]
        end else if (tick) begin
            if (s.wd_cnt <= `SWT_CNT_W'(1)) begin
                next_s.fault     = 1'b1;                          // [RULE8]
                next_s.fault_cnt = RST_US - 1'b1;                 // [RULE13]
            end else begin
                next_s.wd_cnt = s.wd_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s            <= '0;
            s.rst_active <= 1'b1;
            s.sel        <= SWT_SEL_OPEN;
        end else begin
            s <= next_s;
        end
    end

    assign watchdog_fault_out = 1'b0;
    assign watchdog_fault_oe  = s.fault;
    assign reset_out          = 1'b0;
    assign reset_oe           = s.rst_active;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    disabled_release_a: assert property ( // [RULE2]
        !en |=> !s.fault ##1 !s.fault)
        else $error("fault asserted while watchdog disabled");

    reset_block_a: assert property ( // [RULE11]
        s.rst_active |=> !watchdog_fault_oe)
        else $error("fault driven while reset asserted");

    glitch_persist_a: assert property ( // [RULE10]
        $rose(s.rst_active) |-> $past(s.uv_cnt) == GL_CYC
            && $past(s.uv_s[1], 2))
        else $error("reset tripped before persistence time");

    fault_hold_a: assert property ( // [RULE13]
        $rose(s.fault) |-> s.fault_cnt == RST_US - 1'b1
            ##1 (s.fault || !wd_run)[*8])
        else $error("fault not held for reset delay");

    kick_reload_a: assert property ( // [RULE15]
        (wd_run && !s.fault && kick_ok) |=> s.wd_cnt == $past(timeout))
        else $error("kick did not reload the timeout");

    rise_ignore_a: assert property ( // [RULE12]
        (wd_run && !s.fault && !tick && s.kick_s[2:1] == 2'b01
            && !$rose(en)) |=> s.wd_cnt == $past(s.wd_cnt))
        else $error("rising kick edge changed the counter");

    setup_window_a: assert property ( // [RULE14]
        (en && !s.en_s[2]) |=> s.setup_cnt == SETUP_CYC)
        else $error("enable setup window not started");

    expiry_fault_a: assert property ( // [RULE8]
        (wd_run && !s.fault && !kick_ok && tick
            && s.wd_cnt == `SWT_CNT_W'(1)) |=> s.fault)
        else $error("fault missed on timeout expiry");

    factory_long_a: assert property ( // [RULE1]
        (s.sel == SWT_SEL_OPEN) |-> timeout == LONG_US)
        else $error("open strap did not select long period");

    uv_count_clear_a: assert property ( // [RULE10]
        !s.uv_s[1] |=> s.uv_cnt == '0)
        else $error("persistence count kept after dip ended");

    fault_release_a: assert property ( // [RULE13]
        (wd_run && s.fault && tick && s.fault_cnt == '0) |=> !s.fault)
        else $error("fault not released after reset delay");

    setup_ignore_a: assert property ( // [RULE14]
        (wd_run && !s.fault && kick_fall && !tick && s.setup_cnt != '0)
            |=> s.wd_cnt == $past(s.wd_cnt))
        else $error("kick counted inside setup interval");

endmodule : swt_watchdog

// ==== common/swt_consts.svh ====
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH

// Timebase
`define SWT_CLK_MHZ        25
`define SWT_TICK_W         5
// Factory periods, ms
`define SWT_LONG_MS        1600
`define SWT_SHORT_MS       200
// Capacitor timing: standard us = 323 * pF / 100 + 381
`define SWT_STD_MUL_X100   323
`define SWT_STD_DIV        100
`define SWT_STD_OFS_US     381
// Capacitor timing: extended us = 774 * pF / 10 + 55 ms
`define SWT_EXT_MUL_X10    774
`define SWT_EXT_DIV        10
`define SWT_EXT_OFS_MS     55
// Undervoltage persistence and enable setup, us
`define SWT_GLITCH_US      6
`define SWT_SETUP_US       150
// Reset and fault hold delay, ms
`define SWT_RST_DELAY_MS   200
`define SWT_US_PER_MS      1000
// Widths
`define SWT_CNT_W          28
`define SWT_CAP_W          20
`define SWT_GL_W           8
`define SWT_SU_W           12
`define SWT_PROD_W         32

`endif

// ==== common/swt_pkg.sv ====
`include "swt_consts.svh"

package swt_pkg;

    typedef enum logic [1:0] {
        SWT_SEL_OPEN,
        SWT_SEL_PULLUP,
        SWT_SEL_CAP
    } swt_sel_t;

    typedef struct packed {
        logic [2:0]                en_s;
        logic [2:0]                kick_s;
        logic [1:0]                uv_s;
        logic [1:0]                sel_s0;
        logic [1:0]                sel_s1;
        logic [`SWT_CAP_W-1:0]     cap_s0;
        logic [`SWT_CAP_W-1:0]     cap_s1;
        swt_sel_t                  sel;
        logic [`SWT_CAP_W-1:0]     cap;
        logic [`SWT_TICK_W-1:0]    tick_cnt;
        logic [`SWT_GL_W-1:0]      uv_cnt;
        logic                      rst_active;
        logic [`SWT_CNT_W-1:0]     rst_cnt;
        logic [`SWT_SU_W-1:0]      setup_cnt;
        logic [`SWT_CNT_W-1:0]     wd_cnt;
        logic                      fault;
        logic [`SWT_CNT_W-1:0]     fault_cnt;
    } swt_state_t;

endpackage : swt_pkg

// ==== sim/swt_host_model.sv ====
`timescale 1ns/1ps

module swt_host_model (
    input  wire logic       clk,       // Bench clock
    input  wire logic       run,       // Keep kicking while high
    input  wire logic [7:0] period_us, // Kick period in microseconds
    output logic            kick       // Kick line to the watchdog
);
    int half;

    // Falling edge opens each period, rise at mid-period, idles high
    initial begin
        kick = 1'b1;
        forever begin
            @(posedge clk);
            if (run) begin
                half = int'(period_us) * 25 / 2;
                #1 kick = 1'b0;
                repeat (half) @(posedge clk);
                #1 kick = 1'b1;
                repeat (int'(period_us) * 25 - half - 1) @(posedge clk);
            end
        end
    end
endmodule : swt_host_model

// ==== sim/supervisor_watchdog_timeout_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module supervisor_watchdog_timeout_bench;
    import swt_pkg::*;
    typedef struct {int us; bit from_kick;} swt_note_t;
    localparam int LONG = 200, SHORT = 50, RSTU = 20;
    logic clk, nrst, en, uv, run, kick, f_out, f_oe, r_out, r_oe, prev;
    logic [1:0]  sel;
    logic [19:0] cap;
    logic [7:0]  per;
    int miscompares, n_checks, cyc, ref_cyc, last_fall, d, h, seed;
    swt_note_t notes[$];
    swt_note_t n;

    swt_watchdog #(.EXTENDED(1'b0), .LONG_US(28'h0c8), .SHORT_US(28'h032),
        .RST_US(28'h014)) swt_watchdog_inst (
        .clk(clk), .nrst(nrst), .watchdog_enable_pin(en),
        .watchdog_kick_input(kick), .timeout_select_pin(sel),
        .timing_capacitor(cap), .undervoltage_detect(uv),
        .watchdog_fault_out(f_out), .watchdog_fault_oe(f_oe),
        .reset_out(r_out), .reset_oe(r_oe));
    swt_host_model swt_host_model_inst (.clk(clk), .run(run),
        .period_us(per), .kick(kick));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge kick) last_fall = cyc;

    // Each fault rise takes the oldest note and checks its delay
    always @(posedge clk) begin
        cyc++;
        prev <= f_oe;
        if (f_oe === 1'b1 && prev === 1'b0) begin
            if (notes.size() == 0) begin
                `CHK("unexpected fault", 1'b0, 1'b1)
            end else begin
                n = notes.pop_front();
                d = cyc - (n.from_kick ? last_fall : ref_cyc) - n.us*25;
                `CHK("wd delay", 1'b1, d inside {[-30:60]})
            end
        end
    end

    task automatic give_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic wait_fault(input int lim);
        int i;
        for (i = 0; i < lim && f_oe !== 1'b1; i++) @(posedge clk);
        if (f_oe !== 1'b1) begin
            miscompares++;
            $display("ERROR fault wait exp 1 got %0h", f_oe);
            give_verdict();
        end
        #1;
    endtask : wait_fault

    task automatic do_reset(input logic [1:0] s, input logic [19:0] c);
        sel = s;
        cap = c;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        `CHK("reset_oe in reset", 1'b1, r_oe)
        `CHK("fault_oe in reset", 1'b0, f_oe)
        #1 nrst = 1'b1;
        repeat (40) @(posedge clk);
        `CHK("reset_oe released", 1'b0, r_oe)
        `CHK("pin levels", 2'h0, {f_out, r_out})
    endtask : do_reset

    task automatic enable_expect(input int us);
        #1 en = 1'b1;
        ref_cyc = cyc;
        notes.push_back('{us, 1'b0});
    endtask : enable_expect

    initial begin
        seed = 93062;
        {nrst, en, uv, run} = '0;
        sel = 2'h0;
        cap = 20'h0;
        per = 8'h0a;
        do_reset(2'h0, 20'h0);
        // Open strap, a kick inside the setup interval must not count
        enable_expect(LONG);
        repeat (500) @(posedge clk);
        #1 run = 1'b1;
        @(posedge clk);
        #1 run = 1'b0;
        wait_fault(LONG*25+200);
        en = 1'b0;
        repeat (5) @(posedge clk);
        `CHK("fault drop on disable", 1'b0, f_oe)
        // Kicking while disabled has no effect either
        #1 run = 1'b1;
        repeat (2500) @(posedge clk);
        #1 per = 8'(12 + ($random(seed) & 7));
        en = 1'b1;
        repeat (10000) @(posedge clk);
        // Stop kicking; the timeout counts from the last falling edge
        #1 run = 1'b0;
        notes.push_back('{LONG, 1'b1});
        wait_fault(LONG*25+1000);
        for (h = 0; h < 2000 && f_oe === 1'b1; h++) @(posedge clk);
        `CHK("fault hold", 1'b1, h >= RSTU*25-30 && h <= RSTU*25+60)
        #1 en = 1'b0;
        // Undervoltage: short pulse ignored, long one resets the device
        repeat (50) @(posedge clk);
        enable_expect(LONG);
        wait_fault(LONG*25+200);
        uv = 1'b1;
        repeat (100) @(posedge clk);
        #1 uv = 1'b0;
        repeat (60) @(posedge clk);
        `CHK("short dip ignored", 1'b0, r_oe)
        #1 uv = 1'b1;
        repeat (140) @(posedge clk);
        `CHK("reset early", 1'b0, r_oe)
        repeat (25) @(posedge clk);
        `CHK("reset after dip", 1'b1, r_oe)
        `CHK("fault off in reset", 1'b0, f_oe)
        #1 en = 1'b0;
        uv = 1'b0;
        repeat (RSTU*25+100) @(posedge clk);
        `CHK("reset release", 1'b0, r_oe)
        // Pulled-high strap gives the short period
        #1 do_reset(2'h1, 20'h0);
        enable_expect(SHORT);
        wait_fault(SHORT*25+200);
        #1 en = 1'b0;
        // Capacitor strap with a random value near the low end
        do_reset(2'h2, 20'h064 + 20'($random(seed) & 63));
        enable_expect(323 * int'(cap) / 100 + 381);
        wait_fault((323 * int'(cap) / 100 + 420) * 25);
        #1 en = 1'b0;
        repeat (100) @(posedge clk);
        `CHK("queue drained", 0, notes.size())
        give_verdict();
    end
endmodule : supervisor_watchdog_timeout_bench
